// ### design/adc_cal_pkg.sv
/*
 * shared constants and carriers for the converter offset calibration control.
 * assumes a single 200 MHz system clock and an Avalon-MM register master.
 */
package adc_cal_pkg;
    // *****************************************************
    // register map (byte addresses)
    // *****************************************************
    localparam logic [3:0] ctrl_addr = 4'h0;
    localparam logic [3:0] status_addr = 4'h4;
    localparam logic [3:0] irq_stat_addr = 4'h8;
    localparam logic [3:0] irq_mask_addr = 4'hc;
    localparam logic [31:0] unmapped_data = 32'hdeadbeef;
    localparam logic [3:0] user_ofs_addr = 4'h0;
    // ctrl word fields
    localparam int ctrl_pair_bit = 0;
    localparam int ctrl_diff_bit = 1;
    localparam int ctrl_res_lsb = 2;
    localparam int ctrl_wake_bit = 4;
    localparam int ctrl_user_lsb = 16;
    // irq bits
    localparam int irq_icald_bit = 0;
    localparam int irq_scald_bit = 1;
    localparam int irq_conv_bit = 2;
    localparam int irq_width = 3;
    // *****************************************************
    // timing
    // *****************************************************
    localparam int internal_cal_clocks = 6415;
    localparam int sys_cal_clocks = 16;
    localparam int conv_clocks = 16;
    localparam logic [13:0] diff_bias_full = 14'h2000;
    // resolution selection
    typedef enum logic [1:0] {
        res_8 = 2'h0,
        res_10 = 2'h1,
        res_12 = 2'h2,
        res_14 = 2'h3
    } res_e;
    // gray along icald -> idle -> conv -> scal
    typedef enum logic [1:0] {
        st_icald = 2'h0,
        st_idle = 2'h1,
        st_conv = 2'h3,
        st_scal = 2'h2
    } state_e;
    typedef struct packed {
        logic pair_sel;
        logic diff_mode;
        res_e res;
        logic [15:0] user_ofs;
    } cfg_s;
endpackage : adc_cal_pkg

// ### design/adc_offset_calibration_ctrl.sv
/*
 * converter offset calibration sequencer with Avalon-MM register slave.
 * assumes raw converter codes arrive on i_raw_code when a conversion ends,
 * and that the power manager pulses i_wake on each deep-sleep exit.
 */
`timescale 1ns/1ps
module adc_offset_calibration_ctrl #(
    parameter int cal_clocks = adc_cal_pkg::internal_cal_clocks
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_wake,
    input wire logic i_conv_start,
    input wire logic i_cal_start,
    input wire logic [13:0] i_raw_code,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic o_busy,
    output logic o_conv_active,
    output logic [1:0] o_chan_pair,
    output logic [15:0] o_result,
    output logic o_result_valid,
    output logic o_irq
);
    // *****************************************************
    // state and counters
    // *****************************************************
    adc_cal_pkg::state_e state_reg, state_next;
    logic [12:0] cnt_reg, cnt_next;
    logic cal_start_d_reg, cal_start_d_next;
    logic signed [15:0] int_ofs_reg, int_ofs_next;
    logic signed [15:0] sys_ofs_reg, sys_ofs_next;
    logic [15:0] result_reg, result_next;
    logic valid_reg, valid_next;
    adc_cal_pkg::cfg_s cfg_reg, cfg_next;
    logic [adc_cal_pkg::irq_width-1:0] istat_reg, istat_next;
    logic [adc_cal_pkg::irq_width-1:0] imask_reg, imask_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [adc_cal_pkg::irq_width-1:0] ev;
    logic [13:0] midscale;
    logic signed [15:0] corrected;
    logic cal_edge;

    // *****************************************************
    // offset arithmetic
    // *****************************************************
    // midscale follows width; 14 bit diff bias is 8192
    always_comb begin
        unique case (cfg_reg.res)
            adc_cal_pkg::res_8: midscale = adc_cal_pkg::diff_bias_full >> 6;
            adc_cal_pkg::res_10: midscale = adc_cal_pkg::diff_bias_full >> 4;
            adc_cal_pkg::res_12: midscale = adc_cal_pkg::diff_bias_full >> 2;
            adc_cal_pkg::res_14: midscale = adc_cal_pkg::diff_bias_full;
        endcase
    end

    assign cal_edge = i_cal_start & ~cal_start_d_reg;
    // zero-extended raw minus all offsets; clamp is left to the consumer
    assign corrected = $signed({2'b00, i_raw_code}) - int_ofs_reg - sys_ofs_reg
        - $signed(cfg_reg.user_ofs);

    // *****************************************************
    // sequencer
    // *****************************************************
    // one state word arbitrates both strobes, so a conversion and a
    // calibration can never overlap
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        int_ofs_next = int_ofs_reg;
        sys_ofs_next = sys_ofs_reg;
        result_next = result_reg;
        valid_next = 1'b0;
        ev = '0;
        cal_start_d_next = i_cal_start;
        if (i_wake && state_reg != adc_cal_pkg::st_icald) begin
            state_next = adc_cal_pkg::st_icald;
            cnt_next = '0;
        end else begin
            unique case (state_reg)
                adc_cal_pkg::st_icald: begin
                    cnt_next = cnt_reg + 13'h1;
                    if (cnt_reg == 13'(cal_clocks - 1)) begin
                        // converter's own offset loaded with zero at the end, no sample taken
                        int_ofs_next = 16'sh0;
                        state_next = adc_cal_pkg::st_idle;
                        cnt_next = '0;
                        ev[adc_cal_pkg::irq_icald_bit] = 1'b1;
                    end
                end
                adc_cal_pkg::st_idle: begin
                    if (cal_edge) begin
                        state_next = adc_cal_pkg::st_scal;
                    end else if (i_conv_start) begin
                        state_next = adc_cal_pkg::st_conv;
                    end
                    cnt_next = '0;
                end
                adc_cal_pkg::st_conv: begin
                    // a calibration edge here is dropped, not queued
                    cnt_next = cnt_reg + 13'h1;
                    if (cnt_reg == 13'(adc_cal_pkg::conv_clocks - 1)) begin
                        result_next = 16'(corrected);
                        valid_next = 1'b1;
                        state_next = adc_cal_pkg::st_idle;
                        cnt_next = '0;
                        ev[adc_cal_pkg::irq_conv_bit] = 1'b1;
                    end
                end
                adc_cal_pkg::st_scal: begin
                    // conversion starts are not looked at here
                    cnt_next = cnt_reg + 13'h1;
                    if (cnt_reg == 13'(adc_cal_pkg::sys_cal_clocks - 1)) begin
                        if (cfg_reg.diff_mode) begin
                            sys_ofs_next = $signed({2'b00, i_raw_code})
                                - $signed({2'b00, midscale});
                        end else begin
                            sys_ofs_next = $signed({2'b00, i_raw_code});
                        end
                        state_next = adc_cal_pkg::st_idle;
                        cnt_next = '0;
                        ev[adc_cal_pkg::irq_scald_bit] = 1'b1;
                    end
                end
            endcase
        end
    end

    // *****************************************************
    // register slave
    // *****************************************************
    always_comb begin
        cfg_next = cfg_reg;
        imask_next = imask_reg;
        istat_next = istat_reg;
        ack_next = (avs_read | avs_write) & ~ack_reg;
        rdata_next = rdata_reg;
        // writes land on the edge that sees waitrequest low; config is not
        // locked while busy, keeping it still is the user's side
        if (avs_write && ack_reg) begin
            unique case (avs_address)
                adc_cal_pkg::ctrl_addr: begin
                    cfg_next.pair_sel = avs_writedata[adc_cal_pkg::ctrl_pair_bit];
                    cfg_next.diff_mode = avs_writedata[adc_cal_pkg::ctrl_diff_bit];
                    cfg_next.res = adc_cal_pkg::res_e'(avs_writedata[adc_cal_pkg::ctrl_res_lsb +: 2]);
                    cfg_next.user_ofs = avs_writedata[adc_cal_pkg::ctrl_user_lsb +: 16];
                end
                adc_cal_pkg::irq_stat_addr: begin
                    istat_next = istat_reg & ~avs_writedata[adc_cal_pkg::irq_width-1:0];
                end
                adc_cal_pkg::irq_mask_addr: begin
                    imask_next = avs_writedata[adc_cal_pkg::irq_width-1:0];
                end
                default: begin
                end
            endcase
        end
        // hardware set wins over a same-cycle software clear
        istat_next = istat_next | ev;
        if (avs_read && !ack_reg) begin
            unique case (avs_address)
                adc_cal_pkg::ctrl_addr: rdata_next = {cfg_reg.user_ofs, 11'h0, 1'b0, cfg_reg.res,
                    cfg_reg.diff_mode, cfg_reg.pair_sel};
                adc_cal_pkg::status_addr: rdata_next = {result_reg, 13'h0, o_conv_active,
                    (state_reg == adc_cal_pkg::st_scal), o_busy};
                adc_cal_pkg::irq_stat_addr: rdata_next = {29'h0, istat_reg};
                adc_cal_pkg::irq_mask_addr: rdata_next = {29'h0, imask_reg};
                default: rdata_next = adc_cal_pkg::unmapped_data;
            endcase
        end
    end

    // *****************************************************
    // registers
    // *****************************************************
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= adc_cal_pkg::st_icald;
            cnt_reg <= '0;
            cal_start_d_reg <= 1'b0;
            int_ofs_reg <= '0;
            sys_ofs_reg <= '0;
            result_reg <= '0;
            valid_reg <= 1'b0;
            cfg_reg <= '0;
            istat_reg <= '0;
            imask_reg <= '0;
            ack_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            cal_start_d_reg <= cal_start_d_next;
            int_ofs_reg <= int_ofs_next;
            sys_ofs_reg <= sys_ofs_next;
            result_reg <= result_next;
            valid_reg <= valid_next;
            cfg_reg <= cfg_next;
            istat_reg <= istat_next;
            imask_reg <= imask_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // *****************************************************
    // outputs
    // *****************************************************
    // busy is decoded from state, so it drops on the same edge as idle
    assign o_busy = (state_reg == adc_cal_pkg::st_icald)
        || (state_reg == adc_cal_pkg::st_scal);
    assign o_conv_active = (state_reg == adc_cal_pkg::st_conv);
    assign o_chan_pair = cfg_reg.pair_sel ? 2'h1 : 2'h0;
    assign o_result = result_reg;
    assign o_result_valid = valid_reg;
    assign o_irq = |(istat_reg & imask_reg);
    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
endmodule : adc_offset_calibration_ctrl

// ### tb/adc_offset_calibration_ctrl_props.sv
/* checker for the calibration sequencer ports.
   assumes one clock domain and cal_clocks equal to the instance's value. */
`timescale 1ns/1ps
module adc_offset_calibration_ctrl_props #(
    parameter int cal_clocks = adc_cal_pkg::internal_cal_clocks
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_wake,
    input wire logic i_conv_start,
    input wire logic i_cal_start,
    input wire logic o_busy,
    input wire logic o_conv_active,
    input wire logic o_result_valid
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic idle;
    int unsigned since_rst_reg;
    assign idle = !o_busy && !o_conv_active;
    // saturates so the end-of-calibration check fires once per reset
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) since_rst_reg <= 0;
        else if (since_rst_reg < 32'hffff) since_rst_reg <= since_rst_reg + 1;
    end
    chk_busy_conv_excl: assert property (!(o_busy && o_conv_active))
        else $error("busy and conversion together");
    chk_int_cal_hold: assert property (since_rst_reg < cal_clocks |-> o_busy)
        else $error("internal calibration ended early");
    chk_int_cal_end: assert property (since_rst_reg == cal_clocks |-> !o_busy)
        else $error("internal calibration ended late");
    chk_wake_restart: assert property (i_wake |=> o_busy)
        else $error("wake did not start calibration");
    chk_cal_edge: assert property (idle && $rose(i_cal_start) |=> o_busy)
        else $error("calibration edge not taken");
    chk_cal_level: assert property (idle && i_cal_start && $past(i_cal_start) && !i_wake
        && !i_conv_start |=> idle)
        else $error("held level restarted calibration");
    chk_cal_blocked: assert property (o_conv_active && $rose(i_cal_start) && !i_wake
        |=> !o_busy)
        else $error("calibration started during conversion");
    chk_conv_ignored: assert property (o_busy && i_conv_start |=> !o_conv_active)
        else $error("conversion started during calibration");
    chk_sys_cal_len: assert property (idle && $rose(i_cal_start) && !i_wake
        |=> o_busy [*8] ##1 o_busy [*8] ##1 !o_busy)
        else $error("system calibration length wrong");
    chk_conv_answer: assert property (idle && i_conv_start && !$rose(i_cal_start) && !i_wake
        |=> o_conv_active ##16 o_result_valid)
        else $error("conversion result late");
endmodule : adc_offset_calibration_ctrl_props
bind adc_offset_calibration_ctrl adc_offset_calibration_ctrl_props #(.cal_clocks(cal_clocks))
    props_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_wake(i_wake), .i_conv_start(i_conv_start),
    .i_cal_start(i_cal_start), .o_busy(o_busy), .o_conv_active(o_conv_active),
    .o_result_valid(o_result_valid));

// ### tb/cal_strobe_user.sv
/* model of the user logic driving the conversion and calibration strobes.
   assumes the bench sets request levels right after a rising edge. */
`timescale 1ns/1ps
module cal_strobe_user #(
    parameter int hold_clocks = 20
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_req_conv,
    input wire logic i_req_cal,
    input wire logic [13:0] i_level,
    output logic o_conv_start,
    output logic o_cal_start,
    output logic [13:0] o_raw_code
);
    // the same hold also stands for amplifier settling
    int delay_counter;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            delay_counter <= 0;
            o_conv_start <= 1'b0;
            o_cal_start <= 1'b0;
            o_raw_code <= 14'h0;
        end else begin
            if (delay_counter < hold_clocks) delay_counter <= delay_counter + 1;
            o_conv_start <= i_req_conv && (delay_counter >= hold_clocks);
            o_cal_start <= i_req_cal;
            o_raw_code <= i_level;
        end
    end
endmodule : cal_strobe_user

// ### tb/adc_offset_calibration_ctrl_bench.sv
/* bench for the calibration sequencer: register bus tasks and strobe scenarios.
   assumes the strobe partner model and the bound checker. */
`timescale 1ns/1ps
module adc_offset_calibration_ctrl_bench;
    logic sys_clk, rst, wake, conv_start, cal_start, req_conv, req_cal, rd, wr, waitreq;
    logic busy, conv_active, valid, irq;
    logic [13:0] raw, level;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, got;
    logic [1:0] pair;
    logic [15:0] result, mid;
    int fail_count = 0;
    int checked = 0;
    adc_offset_calibration_ctrl #(.cal_clocks(20)) uut (.i_sys_clk(sys_clk), .i_rst(rst),
        .i_wake(wake), .i_conv_start(conv_start), .i_cal_start(cal_start), .i_raw_code(raw),
        .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
        .avs_readdata(rdata), .avs_waitrequest(waitreq), .o_busy(busy),
        .o_conv_active(conv_active), .o_chan_pair(pair), .o_result(result),
        .o_result_valid(valid), .o_irq(irq));
    cal_strobe_user #(.hold_clocks(20)) user_i (.i_sys_clk(sys_clk), .i_rst(rst),
        .i_req_conv(req_conv), .i_req_cal(req_cal), .i_level(level),
        .o_conv_start(conv_start), .o_cal_start(cal_start), .o_raw_code(raw));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        do @(posedge sys_clk); while (waitreq);
        wr <= 1'b0;
    endtask : bus_write
    task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        do @(posedge sys_clk); while (waitreq);
        d = rdata;
        rd <= 1'b0;
    endtask : bus_read
    // poke raises the calibration strobe mid-conversion and holds it three cycles past the result
    task automatic convert(input logic [13:0] r, input logic [15:0] e, input bit poke);
        @(posedge sys_clk);
        level <= r;
        req_conv <= 1'b1;
        do @(posedge sys_clk); while (!conv_active);
        req_conv <= 1'b0;
        if (poke) req_cal <= 1'b1;
        do @(posedge sys_clk); while (!valid);
        check({16'h0, result}, {16'h0, e});
        if (poke) begin
            repeat (3) @(posedge sys_clk);
            check({31'h0, busy}, 32'h0);
            req_cal <= 1'b0;
        end
    endtask : convert
    // poke requests a conversion while the calibration runs
    task automatic calibrate(input logic [13:0] r, input bit poke);
        @(posedge sys_clk);
        level <= r;
        req_cal <= 1'b1;
        do @(posedge sys_clk); while (!busy);
        if (poke) req_conv <= 1'b1;
        repeat (4) @(posedge sys_clk);
        req_conv <= 1'b0;
        do @(posedge sys_clk); while (busy);
        check({31'h0, conv_active}, 32'h0);
        req_cal <= 1'b0;
    endtask : calibrate
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        test_done;
    end
    initial begin
        rst = 1'b1;
        {wake, req_conv, req_cal, rd, wr} = 5'h0;
        level = 14'h0;
        addr = 4'h0;
        wdata = 32'h0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        do @(posedge sys_clk); while (busy);
        bus_read(adc_cal_pkg::irq_stat_addr, got);
        check(got, 32'h1);
        bus_read(4'h2, got);
        check(got, adc_cal_pkg::unmapped_data);
        bus_write(adc_cal_pkg::irq_stat_addr, 32'h7);
        convert(14'h64, 16'h64, 1'b0);
        check({31'h0, irq}, 32'h0);
        for (int r = 0; r < 4; r++) begin
            mid = 16'h0080 << (2 * r);
            bus_write(adc_cal_pkg::ctrl_addr, {28'h0, 2'(r), 1'b1, r[0]});
            @(posedge sys_clk);
            check({30'h0, pair}, {31'h0, r[0]});
            calibrate(14'(mid + 16'(2 * r) - 16'h3), r == 0);
            convert(mid[13:0], mid + 16'h3 - 16'(2 * r), 1'b0);
        end
        bus_write(adc_cal_pkg::ctrl_addr, {16'h0005, 12'h0, 2'h3, 2'h2});
        convert(14'h2000, 16'h1ff8, 1'b1);
        bus_write(adc_cal_pkg::irq_mask_addr, 32'h4);
        convert(14'h10, 16'h8, 1'b0);
        @(posedge sys_clk);
        check({31'h0, irq}, 32'h1);
        bus_write(adc_cal_pkg::irq_stat_addr, 32'h7);
        @(posedge sys_clk);
        check({31'h0, irq}, 32'h0);
        wake <= 1'b1;
        @(posedge sys_clk);
        wake <= 1'b0;
        @(posedge sys_clk);
        check({31'h0, busy}, 32'h1);
        do @(posedge sys_clk); while (busy);
        test_done;
    end
endmodule : adc_offset_calibration_ctrl_bench
